// >>> core/uartf_pkg.sv
// How it works
// - baud divisor is 22 bits: 16-bit integer, 6-bit fraction.
// - divisor is refclk over 16 times baud; fraction counts sixty-fourths.
// - rate generator pulses sixteen times baud; sixteen pulses make one bit.
// - when enabled with transmit data queued, frames go out until empty.
// - busy rises with queued data, falls after last stop bit leaves.
// - each received bit is a majority of three samples around midpoint.
// - low from idle starts counting; start accepted only if low at middle.
// - data bits sampled every sixteen ticks, then parity checked if enabled.
// - low stop bit flags framing error; word stored with its flags.
// - receive entry: data 7:0, framing 8, parity 9, break 10, overrun 11.
// - word finished while receive queue full sets overrun and is dropped.
// - pending overrun rides with next stored word, then clears.
// - both queues hold 32 entries; receive entries carry four status bits.
// - queues disabled act as one-entry holders; overrun if unread.
// - queues disabled, a data write loads an idle shifter directly.
// - loopback routes transmit output into receiver.
// - with rts flow on, rts stays asserted until fill reaches watermark.
// - with cts flow on, transmission starts only while cts asserted.
// - two independent bits enable cts and rts flow control.
// - line control is one 30-bit word from three register writes.
// - frame: start, data lsb first, optional parity, stop bits.
// - word length 5 to 8 bits; one or two stop bits.
// - rts reasserts once reads bring fill below watermark.
// - cts dropping lets the current character finish, then stops.
package uartf_pkg;
   // register byte offsets
   localparam logic [7:0] A_DATA = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_IBRD = 8'h08;
   localparam logic [7:0] A_FBRD = 8'h0c;
   localparam logic [7:0] A_LCR  = 8'h10;
   localparam logic [7:0] A_CTRL = 8'h14;
   // line control bit positions
   localparam int L_BRK = 0;
   localparam int L_PEN = 1;
   localparam int L_EPS = 2;
   localparam int L_STP2 = 3;
   localparam int L_FEN = 4;
   localparam int L_WLEN = 5;
   // control bit positions
   localparam int C_EN = 0;
   localparam int C_LOOP = 1;
   localparam int C_RTS = 2;
   localparam int C_RTSF = 3;
   localparam int C_CTSF = 4;
   localparam int C_WM = 5;
   // reset values
   localparam logic [7:0]  LCR_RST  = 8'h00;
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [15:0] IBRD_RST = 16'h0000;
   localparam logic [5:0]  FBRD_RST = 6'h00;
   // counts
   localparam logic [5:0] DEPTH = 6'h20;
   localparam logic [3:0] MID   = 4'h8;
   localparam logic [3:0] LAST_TICK = 4'hf;
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   typedef struct packed {
      logic       ovr;
      logic       brk;
      logic       par;
      logic       fe;
      logic [7:0] data;
   } uartf_rxent_t;
   typedef struct packed {
      logic [7:0]  lcr;
      logic [15:0] ibrd;
      logic [5:0]  fbrd;
   } uartf_lcr_t;
   typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} uartf_tx_t;
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} uartf_rx_t;
endpackage : uartf_pkg

// >>> core/uartf_core.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module uartf_core (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial pins
   input  wire logic        serial_rx_in,
   output logic             serial_tx_out,
   input  wire logic        clear_to_send_n,
   output logic             request_to_send_n
);
   ////////////////////////////////////////////////////////////////////////////
   uartf_pkg::uartf_lcr_t     line_control_internal;
   logic [7:0]                control_reg;
   uartf_pkg::uartf_tx_t      txs;
   uartf_pkg::uartf_rx_t      rxs;
   logic [15:0]               div_cnt;
   logic [5:0]                frac_acc;
   logic                      aw_h, w_h;
   logic [7:0]                waddr;
   logic [31:0]               wdat;
   logic [3:0]                wstb;
   logic [7:0]                tx_mem [32];
   uartf_pkg::uartf_rxent_t   rx_mem [32];
   logic [4:0]                tx_wp, tx_rp, rx_wp, rx_rp;
   logic [5:0]                tx_cnt, rx_cnt;
   logic [7:0]                tx_sh;
   logic [3:0]                tcnt, rcnt;
   logic [2:0]                tbit, rbit;
   logic                      tstop2;
   logic                      rx_s1, rx_s2, cts_s1, cts_s2, rx_prev;
   logic [1:0]                hist;
   logic [7:0]                rdat;
   logic                      allz, perr, ovr_q, busy_q;
   logic [31:0]               rmux;
   logic                      rerr;
   logic [5:0]                wm;

   ////////////////////////////////////////////////////////////////////////////
   // decoded control fields
   wire [7:0]  lcr    = line_control_internal.lcr;
   wire [15:0] div_int_part  = line_control_internal.ibrd;
   wire [5:0]  div_frac_part = line_control_internal.fbrd;
   wire        fen    = lcr[uartf_pkg::L_FEN];
   wire        brk    = lcr[uartf_pkg::L_BRK];
   wire        pen    = lcr[uartf_pkg::L_PEN];
   wire [1:0]  wlen   = lcr[uartf_pkg::L_WLEN +: 2];
   wire [2:0]  wl_m1  = {1'b1, wlen} - 3'h4 + 3'h4;  // word length minus one
   wire        uart_en = control_reg[uartf_pkg::C_EN];
   wire        loopback_enable = control_reg[uartf_pkg::C_LOOP];
   wire        rts_flow_enable = control_reg[uartf_pkg::C_RTSF];
   wire        cts_flow_enable = control_reg[uartf_pkg::C_CTSF];
   wire [7:0]  wmask  = 8'hff >> (2'h3 - wlen);
   // a disabled queue holds one entry at a time in its rotating slots, so capacity drops to one
   wire [5:0]  cap    = fen ? uartf_pkg::DEPTH : 6'h01;
   wire        tx_full  = tx_cnt >= cap;
   wire        rx_full  = rx_cnt >= cap;
   wire        rx_empty = rx_cnt == 6'h00;
   wire        cts_ok   = !cts_flow_enable || !cts_s2;

   ////////////////////////////////////////////////////////////////////////////
   // fractional rate generator: fraction carry stretches one period by a cycle
   wire [6:0]  acc_sum = {1'b0, frac_acc} + {1'b0, div_frac_part};
   wire        oversample_tick = (div_int_part != 16'h0000) && (div_cnt == 16'h0000);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt  <= 16'h0000;
         frac_acc <= 6'h00;
      end else if (oversample_tick) begin
         frac_acc <= acc_sum[5:0];
         div_cnt  <= div_int_part - 16'h0001 + {15'h0000, acc_sum[6]};
      end else if (div_cnt != 16'h0000) begin
         div_cnt  <= div_cnt - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data may arrive in either order
   wire do_wr  = aw_h && w_h && !s_axi_bvalid;
   wire aw_map = (waddr == uartf_pkg::A_DATA) || (waddr == uartf_pkg::A_STAT) ||
                 (waddr == uartf_pkg::A_IBRD) || (waddr == uartf_pkg::A_FBRD) ||
                 (waddr == uartf_pkg::A_LCR)  || (waddr == uartf_pkg::A_CTRL);
   wire wr_tx  = do_wr && waddr == uartf_pkg::A_DATA && wstb[0];
   wire rd_hs  = s_axi_arvalid && s_axi_arready;
   wire rx_pop = rd_hs && s_axi_araddr == uartf_pkg::A_DATA && !rx_empty;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_h          <= 1'b0;
         w_h           <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= uartf_pkg::RESP_OK;
         waddr         <= 8'h00;
         wdat          <= 32'h00000000;
         wstb          <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_h          <= 1'b1;
            waddr         <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_h          <= 1'b1;
            wdat         <= s_axi_wdata;
            wstb         <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_map ? uartf_pkg::RESP_OK : uartf_pkg::RESP_ERR;
            aw_h         <= 1'b0;
            w_h          <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // configuration registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_control_internal <= {uartf_pkg::LCR_RST, uartf_pkg::IBRD_RST,
                                   uartf_pkg::FBRD_RST};
         control_reg           <= uartf_pkg::CTRL_RST;
      end else if (do_wr) begin
         if (waddr == uartf_pkg::A_IBRD && wstb[0])
            line_control_internal.ibrd[7:0] <= wdat[7:0];
         if (waddr == uartf_pkg::A_IBRD && wstb[1])
            line_control_internal.ibrd[15:8] <= wdat[15:8];
         if (waddr == uartf_pkg::A_FBRD && wstb[0])
            line_control_internal.fbrd <= wdat[5:0];
         if (waddr == uartf_pkg::A_LCR && wstb[0])
            line_control_internal.lcr <= wdat[7:0];
         if (waddr == uartf_pkg::A_CTRL && wstb[0])
            control_reg <= wdat[7:0];
      end
   end

   // read mux; reading data pops the oldest receive entry
   always_comb begin
      rmux = 32'h00000000;
      rerr = 1'b0;
      if (s_axi_araddr == uartf_pkg::A_DATA) begin
         if (!rx_empty) rmux = {20'h00000, rx_mem[rx_rp]};
      end else if (s_axi_araddr == uartf_pkg::A_STAT) begin
         rmux = {26'h0000000, busy_q, ovr_q, rx_full, rx_empty, tx_full,
                 tx_cnt == 6'h00};
      end else if (s_axi_araddr == uartf_pkg::A_IBRD) begin
         rmux = {16'h0000, div_int_part};
      end else if (s_axi_araddr == uartf_pkg::A_FBRD) begin
         rmux = {26'h0000000, div_frac_part};
      end else if (s_axi_araddr == uartf_pkg::A_LCR) begin
         rmux = {24'h000000, lcr};
      end else if (s_axi_araddr == uartf_pkg::A_CTRL) begin
         rmux = {24'h000000, control_reg};
      end else begin
         rerr = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= uartf_pkg::RESP_OK;
      end else if (rd_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rmux;
         s_axi_rresp   <= rerr ? uartf_pkg::RESP_ERR : uartf_pkg::RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit queue; an idle shifter with queues off takes the write directly
   wire bypass = !fen && txs == uartf_pkg::T_IDLE && uart_en && cts_ok &&
                 tx_cnt == 6'h00;
   wire tx_push = wr_tx && !tx_full && !bypass;
   wire tx_pop  = txs == uartf_pkg::T_IDLE && tx_cnt != 6'h00 && uart_en && cts_ok;
   wire tx_load = tx_pop || (wr_tx && bypass);
   always_ff @(posedge aclk) begin
      if (tx_push) tx_mem[tx_wp] <= wdat[7:0];
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_wp  <= 5'h00;
         tx_rp  <= 5'h00;
         tx_cnt <= 6'h00;
      end else begin
         if (tx_push) tx_wp <= tx_wp + 5'h01;
         if (tx_pop)  tx_rp <= tx_rp + 5'h01;
         tx_cnt <= tx_cnt + {5'h00, tx_push} - {5'h00, tx_pop};
      end
   end

   // transmit shifter: sixteen ticks per bit, lsb first
   wire tbit_end = oversample_tick && tcnt == uartf_pkg::LAST_TICK;
   wire tpar = ^(tx_sh & wmask) ^ ~lcr[uartf_pkg::L_EPS];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txs    <= uartf_pkg::T_IDLE;
         tcnt   <= 4'h0;
         tbit   <= 3'h0;
         tstop2 <= 1'b0;
         tx_sh  <= 8'h00;
      end else begin
         if (oversample_tick) tcnt <= tcnt + 4'h1;
         case (txs)
            uartf_pkg::T_IDLE: begin
               if (tx_load) begin
                  tx_sh <= tx_pop ? tx_mem[tx_rp] : wdat[7:0];
                  tcnt  <= 4'h0;
                  txs   <= uartf_pkg::T_START;
               end
            end
            uartf_pkg::T_START: begin
               if (tbit_end) begin
                  tbit <= 3'h0;
                  txs  <= uartf_pkg::T_DATA;
               end
            end
            uartf_pkg::T_DATA: begin
               if (tbit_end && tbit == wl_m1) begin
                  tstop2 <= 1'b0;
                  txs    <= pen ? uartf_pkg::T_PAR : uartf_pkg::T_STOP;
               end else if (tbit_end) begin
                  tbit <= tbit + 3'h1;
               end
            end
            uartf_pkg::T_PAR: begin
               if (tbit_end) txs <= uartf_pkg::T_STOP;
            end
            default: begin
               // cts is only consulted in idle, so a frame always completes
               if (tbit_end && lcr[uartf_pkg::L_STP2] && !tstop2) begin
                  tstop2 <= 1'b1;
               end else if (tbit_end) begin
                  txs <= uartf_pkg::T_IDLE;
               end
            end
         endcase
      end
   end

   // line level is registered so the pin never glitches
   wire line_d = brk ? 1'b0 :
                 txs == uartf_pkg::T_START ? 1'b0 :
                 txs == uartf_pkg::T_DATA  ? tx_sh[tbit] :
                 txs == uartf_pkg::T_PAR   ? tpar : 1'b1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_tx_out <= 1'b1;
         busy_q        <= 1'b0;
      end else begin
         serial_tx_out <= line_d;
         busy_q <= tx_cnt != 6'h00 || txs != uartf_pkg::T_IDLE || tx_load;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; loopback takes the registered transmit line
   wire rx_in = loopback_enable ? serial_tx_out : rx_s2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1   <= 1'b1;
         rx_s2   <= 1'b1;
         cts_s1  <= 1'b1;
         cts_s2  <= 1'b1;
         rx_prev <= 1'b1;
         hist    <= 2'b11;
      end else begin
         rx_s1   <= serial_rx_in;
         rx_s2   <= rx_s1;
         cts_s1  <= clear_to_send_n;
         cts_s2  <= cts_s1;
         rx_prev <= rx_in;
         if (oversample_tick) hist <= {hist[0], rx_in};
      end
   end

   // receiver: vote at ticks 6, 7, 8 of each bit; 4-bit counter wraps per bit
   wire vote = (hist[1] & hist[0]) | (hist[1] & rx_in) | (hist[0] & rx_in);
   wire mid  = oversample_tick && rcnt == uartf_pkg::MID;
   wire rpar = ^(rdat & wmask) ^ ~lcr[uartf_pkg::L_EPS];
   wire rx_done = mid && rxs == uartf_pkg::R_STOP;
   wire rx_push = rx_done && !rx_full;
   uartf_pkg::uartf_rxent_t went;
   assign went = '{ovr: ovr_q, brk: !vote && allz, par: perr, fe: !vote, data: rdat};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxs  <= uartf_pkg::R_IDLE;
         rcnt <= 4'h0;
         rbit <= 3'h0;
         rdat <= 8'h00;
         allz <= 1'b0;
         perr <= 1'b0;
      end else begin
         if (oversample_tick) rcnt <= rcnt + 4'h1;
         case (rxs)
            uartf_pkg::R_IDLE: begin
               if (uart_en && rx_prev && !rx_in) begin
                  rcnt <= 4'h0;
                  rxs  <= uartf_pkg::R_START;
               end
            end
            uartf_pkg::R_START: begin
               if (mid) begin
                  rbit <= 3'h0;
                  rdat <= 8'h00;
                  allz <= 1'b1;
                  perr <= 1'b0;
                  rxs  <= vote ? uartf_pkg::R_IDLE : uartf_pkg::R_DATA;
               end
            end
            uartf_pkg::R_DATA: begin
               if (mid) begin
                  rdat[rbit] <= vote;
                  allz       <= allz & ~vote;
                  rbit       <= rbit + 3'h1;
                  if (rbit == wl_m1)
                     rxs <= pen ? uartf_pkg::R_PAR : uartf_pkg::R_STOP;
               end
            end
            uartf_pkg::R_PAR: begin
               if (mid) begin
                  perr <= vote != rpar;
                  allz <= allz & ~vote;
                  rxs  <= uartf_pkg::R_STOP;
               end
            end
            default: begin
               if (mid) rxs <= uartf_pkg::R_IDLE;
            end
         endcase
      end
   end

   // receive queue with pending overrun; hardware alone sets and clears it
   always_ff @(posedge aclk) begin
      if (rx_push) rx_mem[rx_wp] <= went;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_wp  <= 5'h00;
         rx_rp  <= 5'h00;
         rx_cnt <= 6'h00;
         ovr_q  <= 1'b0;
      end else begin
         if (rx_push) rx_wp <= rx_wp + 5'h01;
         if (rx_pop)  rx_rp <= rx_rp + 5'h01;
         rx_cnt <= rx_cnt + {5'h00, rx_push} - {5'h00, rx_pop};
         if (rx_done) ovr_q <= rx_full;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rts watermark: eighths of the queue depth
   always_comb begin
      case (control_reg[uartf_pkg::C_WM +: 3])
         3'h0:    wm = 6'h04;
         3'h1:    wm = 6'h08;
         3'h2:    wm = 6'h10;
         3'h3:    wm = 6'h18;
         default: wm = 6'h1c;
      endcase
   end
   wire [5:0] rts_lim = fen ? wm : 6'h01;
   always_ff @(posedge aclk) begin
      if (!aresetn) request_to_send_n <= 1'b1;
      else if (rts_flow_enable) request_to_send_n <= rx_cnt >= rts_lim;
      else request_to_send_n <= ~control_reg[uartf_pkg::C_RTS];
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_div;
      (oversample_tick && div_int_part == 16'h0005 && div_frac_part == 6'h00)
         |=> !oversample_tick [*4] ##1 oversample_tick;
   endproperty
   a_div: assert property (p_div) else $error("tick period wrong");
   property p_tick;
      (oversample_tick && div_int_part > 16'h0001) |=> !oversample_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick not one cycle");
   property p_busy;
      (tx_cnt != 6'h00) |=> busy_q;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low with data");
   property p_idle;
      (txs == uartf_pkg::T_IDLE && !brk && !tx_load) |=> serial_tx_out;
   endproperty
   a_idle: assert property (p_idle) else $error("idle line not high");
   property p_start;
      (txs == uartf_pkg::T_START && !brk) |=> !serial_tx_out;
   endproperty
   a_start: assert property (p_start) else $error("start bit not low");
   property p_cts;
      (txs == uartf_pkg::T_IDLE && cts_flow_enable && cts_s2) |=> txs == uartf_pkg::T_IDLE;
   endproperty
   a_cts: assert property (p_cts) else $error("sent without cts");
   property p_byp;
      (wr_tx && bypass) |=> txs == uartf_pkg::T_START && tx_cnt == 6'h00;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass missed");
   property p_ovr;
      (rx_done && rx_full && !rx_pop) |=> ovr_q && rx_cnt == $past(rx_cnt);
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not set");
   property p_ovrc;
      (rx_done && !rx_full) |=> !ovr_q && rx_mem[$past(rx_wp)].ovr == $past(ovr_q);
   endproperty
   a_ovrc: assert property (p_ovrc) else $error("overrun not carried");
   property p_rts;
      (rts_flow_enable && rx_cnt >= rts_lim) |=> request_to_send_n;
   endproperty
   a_rts: assert property (p_rts) else $error("rts not dropped");
   property p_rtsr;
      (rts_flow_enable && rx_cnt < rts_lim) |=> !request_to_send_n;
   endproperty
   a_rtsr: assert property (p_rtsr) else $error("rts not reasserted");

   c_frame: cover property (txs == uartf_pkg::T_STOP ##1 txs == uartf_pkg::T_IDLE);
   c_push:  cover property (rx_push && !went.fe);
   c_ovr:   cover property (rx_done && rx_full);
   c_false: cover property (mid && rxs == uartf_pkg::R_START && vote);
endmodule : uartf_core

// >>> testbench/uartf_peer.sv
`timescale 1ns/1ps
// far-side serial device: drives our receive line and clear-to-send
module uartf_peer (
   // clock
   input wire logic aclk,
   // serial pins toward the core
   output logic     rx_line,
   output logic     cts_n
);
   initial begin
      rx_line = 1'b1;
      cts_n   = 1'b0;
   end
   // caller packs fr as start, data lsb first, stop; 16 cycles a bit
   task automatic send(input logic [9:0] fr);
      for (int i = 0; i < 10; i++) begin
         @(posedge aclk);
         rx_line <= fr[i];
         repeat (15) @(posedge aclk);
      end
      @(posedge aclk);
      rx_line <= 1'b1; // back to idle mark
   endtask : send
endmodule : uartf_peer

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        aclk, aresetn, awv, wv, br, arv, rr, awr, wrdy, bv, arr, rv, tx, rx, cts_n, rts_n;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat, d;
   logic [1:0]  bresp, bres, rresp, rres;
   int          n_mismatch = 0, tests_run = 0;
   uartf_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .serial_rx_in(rx),
      .serial_tx_out(tx), .clear_to_send_n(cts_n), .request_to_send_n(rts_n));
   uartf_peer u_peer (.aclk(aclk), .rx_line(rx), .cts_n(cts_n));
   // reference clock is aclk itself, so the ratio limit always holds
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bready raised with the request; each channel dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awa <= a;
      wd  <= v;
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (!bv);
      bres = bresp;
      br  <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d  = rdat;
      rres = rresp;
      rr <= 1'b0;
   endtask : rd
   // sample mid-bit of every bit in one outgoing frame
   task automatic cap(input logic [7:0] b);
      logic [9:0] f;
      for (int i = 0; i < 4000 && tx !== 1'b0; i++) @(posedge aclk);
      repeat (8) @(posedge aclk);
      for (int k = 0; k < 10; k++) begin
         f[k] = tx;
         repeat (16) @(posedge aclk);
      end
      chk({22'h0, f}, {22'h0, 1'b1, b, 1'b0});
   endtask : cap
   task automatic t_tx;
      chk({31'h0, tx}, 32'h1);
      wr(uartf_pkg::A_DATA, 32'h55);
      rd(uartf_pkg::A_STAT);
      chk(d & 32'h20, 32'h20);
      cap(8'h55);
      repeat (20) @(posedge aclk);
      rd(uartf_pkg::A_STAT);
      chk(d, 32'h05);
      wr(uartf_pkg::A_LCR, 32'h71);
      repeat (2) @(posedge aclk);
      chk({31'h0, tx}, 32'h0);
      wr(uartf_pkg::A_LCR, 32'h70);
   endtask : t_tx
   // one good frame, one bad stop, one break
   task automatic t_rx;
      logic [9:0] fr[3] = '{10'h346, 10'h078, 10'h000};
      logic [31:0] ex[3] = '{32'h0a3, 32'h13c, 32'h500};
      for (int i = 0; i < 3; i++) begin
         u_peer.send(fr[i]);
         rd(uartf_pkg::A_DATA);
         chk(d, ex[i]);
      end
   endtask : t_rx
   // a divisor of five lets the tick period checks see a multi-cycle period
   task automatic t_baud;
      wr(uartf_pkg::A_IBRD, 32'h5);
      repeat (30) @(posedge aclk);
      rd(uartf_pkg::A_IBRD);
      chk(d, 32'h5);
      wr(uartf_pkg::A_IBRD, 32'h1);
   endtask : t_baud
   // seven data bits, even parity: one good frame, one bad parity bit
   task automatic t_par;
      wr(uartf_pkg::A_LCR, 32'h56);
      u_peer.send(10'h26a);
      rd(uartf_pkg::A_DATA);
      chk(d, 32'h035);
      u_peer.send(10'h36a);
      rd(uartf_pkg::A_DATA);
      chk(d, 32'h235);
      wr(uartf_pkg::A_LCR, 32'h70);
   endtask : t_par
   task automatic t_loop;
      wr(uartf_pkg::A_CTRL, 32'h3);
      wr(uartf_pkg::A_DATA, 32'h96);
      repeat (200) @(posedge aclk);
      rd(uartf_pkg::A_DATA);
      chk(d, 32'h96);
   endtask : t_loop
   // cts dropped early in the first start bit: that frame completes, the next waits
   task automatic t_cts;
      u_peer.cts_n <= 1'b1;
      wr(uartf_pkg::A_CTRL, 32'h11);
      wr(uartf_pkg::A_DATA, 32'h0f);
      wr(uartf_pkg::A_DATA, 32'hf0);
      repeat (60) @(posedge aclk);
      chk({31'h0, tx}, 32'h1);
      u_peer.cts_n <= 1'b0;
      repeat (6) @(posedge aclk);
      u_peer.cts_n <= 1'b1;
      cap(8'h0f);
      repeat (60) @(posedge aclk);
      chk({31'h0, tx}, 32'h1);
      u_peer.cts_n <= 1'b0;
      cap(8'hf0);
   endtask : t_cts
   // watermark code 0 means four entries
   task automatic t_rts;
      wr(uartf_pkg::A_CTRL, 32'h05);
      repeat (2) @(posedge aclk);
      chk({31'h0, rts_n}, 32'h0);
      wr(uartf_pkg::A_CTRL, 32'h09);
      repeat (2) @(posedge aclk);
      chk({31'h0, rts_n}, 32'h0);
      for (int i = 0; i < 4; i++) u_peer.send(10'h3fe);
      chk({31'h0, rts_n}, 32'h1);
      rd(uartf_pkg::A_DATA);
      repeat (4) @(posedge aclk);
      chk({31'h0, rts_n}, 32'h0);
   endtask : t_rts
   // single holder: second word is lost, overrun rides on the third
   task automatic t_ovr;
      for (int i = 0; i < 3; i++) begin
         rd(uartf_pkg::A_DATA);
         chk(d, 32'hff);
      end
      wr(uartf_pkg::A_CTRL, 32'h1);
      wr(uartf_pkg::A_LCR, 32'h60);
      u_peer.send(10'h222);
      u_peer.send(10'h244);
      rd(uartf_pkg::A_DATA);
      chk(d, 32'h11);
      u_peer.send(10'h266);
      rd(uartf_pkg::A_DATA);
      chk(d, 32'h833);
      wr(uartf_pkg::A_DATA, 32'h5a);
      cap(8'h5a);
      wr(8'h40, 32'h0);
      chk({30'h0, bres}, {30'h0, uartf_pkg::RESP_ERR});
      rd(8'h40);
      chk({30'h0, rres}, {30'h0, uartf_pkg::RESP_ERR});
   endtask : t_ovr
   task automatic end_sim;
      if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   initial begin
      {aresetn, awv, wv, br, arv, rr} = '0;
      {awa, ara, wd} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wr(uartf_pkg::A_IBRD, 32'h1);
      wr(uartf_pkg::A_FBRD, 32'h0);
      wr(uartf_pkg::A_LCR, 32'h70);
      wr(uartf_pkg::A_CTRL, 32'h1);
      t_baud();
      t_tx();
      t_rx();
      t_par();
      t_loop();
      t_cts();
      t_rts();
      t_ovr();
      end_sim();
   end
   // the full sequence needs about 3100 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end
endmodule : testbench
